// File: core/lpi_pin_interface.sv
// Device-side pin interface of a low-power DDR SDRAM
`timescale 1ns/1ns
`include "lpi_params.svh"
// What this block does
// - Commands registered on rising clock crossing
// - Data moves on both clock crossings
// - Clock enable gates inputs and drivers
// - Enable low enters power-down or self refresh
// - Enable synchronous except self refresh exit
// - Power-down disables all inputs but enable
// - Chip select high masks every command
// - Four strobes jointly encode the command
// - Masked bytes are not written
// - Masks sampled on both data edges
// - Bank inputs pick one of four banks
// - Bank inputs pick the mode register
// - Address carries row, column, auto precharge
// - Precharge bit ten: one or all banks
// - Address carries mode register op-code
// - Strobe edge-aligned on read, centred write
// - Temperature flag high above threshold
// - Data bus width configurable, per-byte strobes
module lpi_pin_interface
  import lpi_pkg::*;
#(
  parameter int DQ_W = `LPI_DQ_W,
  parameter int NB = DQ_W / 8,
  parameter int COL_BITS = `LPI_COL_BITS,
  parameter int BURST_LEN = `LPI_BURST_LEN,
  parameter int BUF_DEPTH = `LPI_BUF_DEPTH
) (
  // Core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link clock and command pins
  input wire logic ck,
  input wire logic cke,
  input wire lpi_ca_t ca,
  // Data pins
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic [DQ_W-1:0] dq_oe,
  input wire logic [NB-1:0] dqs_in,
  output logic [NB-1:0] dqs_out,
  output logic [NB-1:0] dqs_oe,
  input wire logic [NB-1:0] dm,
  // Temperature
  input wire logic [`LPI_TEMP_W-1:0] temp_c,
  output logic over_temp_flag_out,
  // Core-side command stream and status
  output logic cmd_valid,
  output lpi_cmd_rec_t cmd_rec,
  input wire logic cmd_ready,
  output lpi_pwr_t power_state,
  output logic cmd_overflow
);
  localparam int IW = `LPI_BA_W + COL_BITS;
  localparam int MEM_N = `LPI_NBANK << COL_BITS;
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam logic [3:0] HALF = 4'(BURST_LEN / 2);
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(BUF_DEPTH);

  // ----------------------------------------
  // Reset release, one copy per domain
  // ----------------------------------------
  logic [1:0] core_rst_sync;
  logic [1:0] link_rst_sync;
  logic core_rst_n;
  logic link_rst_n;
  assign core_rst_n = core_rst_sync[1];
  assign link_rst_n = link_rst_sync[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) core_rst_sync <= 2'h0;
    else core_rst_sync <= {core_rst_sync[0], 1'b1};
  end

  always_ff @(posedge ck or negedge rst_n) begin
    if (!rst_n) link_rst_sync <= 2'h0;
    else link_rst_sync <= {link_rst_sync[0], 1'b1};
  end

  // ----------------------------------------
  // Command capture and decode
  // ----------------------------------------
  logic cke_q;
  logic cke_d;
  lpi_ca_t ca_q;
  lpi_cmd_t dec_cmd;
  logic cmd_fire;
  logic sr_enter;
  logic pd_enter;
  logic ap;
  logic [`LPI_NBANK-1:0] bank_sel;
  logic [`LPI_NBANK-1:0] open_bank;
  logic [`LPI_NBANK-1:0] next_open;
  lpi_pwr_t pwr;
  lpi_pwr_t next_pwr;

  // Inputs are only taken while the previous enable was high
  always_ff @(posedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      cke_q <= 1'b0;
      cke_d <= 1'b0;
      ca_q <= LPI_CA_IDLE;
    end else begin
      cke_q <= cke;
      cke_d <= cke_q;
      ca_q <= cke_q ? ca : LPI_CA_IDLE;
    end
  end

  assign dec_cmd = lpi_decode(ca_q);
  assign cmd_fire = (pwr == PWR_ACTIVE) && cke_d && (dec_cmd != CMD_DESEL)
                    && (dec_cmd != CMD_NOP);
  assign sr_enter = cmd_fire && (dec_cmd == CMD_REF) && !cke_q;
  assign pd_enter = (pwr == PWR_ACTIVE) && cke_d && !cke_q && !sr_enter;
  assign ap = ca_q.a[`LPI_AP_BIT];
  assign bank_sel = `LPI_NBANK'(1) << ca_q.ba;

  always_comb begin
    next_open = open_bank;
    if (cmd_fire) begin
      case (dec_cmd)
        CMD_ACT: next_open = open_bank | bank_sel;
        CMD_PRE: next_open = ap ? '0 : (open_bank & ~bank_sel);
        CMD_RD, CMD_WR: if (ap) next_open = open_bank & ~bank_sel;
        default: next_open = open_bank;
      endcase
    end
  end

  // ----------------------------------------
  // Power state
  // ----------------------------------------
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      PWR_ACTIVE: begin
        if (sr_enter) next_pwr = PWR_SELF_REF;
        else if (pd_enter) next_pwr = (|open_bank) ? PWR_PD_ACT : PWR_PD_PRE;
      end
      PWR_PD_PRE, PWR_PD_ACT: if (cke_q) next_pwr = PWR_ACTIVE;
      // Exit looks at the raw pin, no registered enable needed
      PWR_SELF_REF: if (cke) next_pwr = PWR_ACTIVE;
      default: next_pwr = PWR_ACTIVE;
    endcase
  end

  always_ff @(posedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      pwr <= PWR_ACTIVE;
      open_bank <= '0;
    end else begin
      pwr <= next_pwr;
      open_bank <= next_open;
    end
  end

  // ----------------------------------------
  // Burst sequencing
  // ----------------------------------------
  logic [DQ_W-1:0] mem [0:MEM_N-1];
  logic [3:0] wr_left;
  logic [3:0] rd_left;
  logic [`LPI_BA_W-1:0] wr_bank;
  logic [`LPI_BA_W-1:0] rd_bank;
  logic [COL_BITS-1:0] wr_col;
  logic [COL_BITS-1:0] rd_col;
  logic pos_taken;
  logic rd_on;
  logic wr_start;
  logic rd_start;
  logic pos_wr;
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] rd_idx;
  logic [IW-1:0] rd_idx_n;
  logic [DQ_W-1:0] dq_p;
  logic [DQ_W-1:0] dq_n;
  logic neg_pend;
  logic [DQ_W-1:0] neg_dq;
  logic [NB-1:0] neg_dm;
  logic [IW-1:0] neg_idx;

  assign wr_start = cmd_fire && (dec_cmd == CMD_WR);
  assign rd_start = cmd_fire && (dec_cmd == CMD_RD);
  assign pos_wr = (wr_left != 4'h0) && cke_q;
  assign wr_idx = {wr_bank, wr_col};
  assign rd_idx = {rd_bank, rd_col};
  assign rd_idx_n = {rd_bank, rd_col - COL_BITS'(1)};

  always_ff @(posedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      wr_left <= 4'h0;
      wr_bank <= '0;
      wr_col <= '0;
      pos_taken <= 1'b0;
    end else begin
      if (wr_start) begin
        wr_left <= HALF;
        wr_bank <= ca_q.ba;
        wr_col <= ca_q.a[COL_BITS-1:0];
      end else if (wr_left != 4'h0) begin
        wr_left <= wr_left - 4'h1;
        wr_col <= wr_col + COL_BITS'(2);
      end
      pos_taken <= pos_wr;
    end
  end

  always_ff @(posedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rd_left <= 4'h0;
      rd_bank <= '0;
      rd_col <= '0;
      rd_on <= 1'b0;
      dq_p <= '0;
    end else begin
      rd_on <= (rd_left != 4'h0) && cke_q;
      if (rd_start) begin
        rd_left <= HALF;
        rd_bank <= ca_q.ba;
        rd_col <= ca_q.a[COL_BITS-1:0];
      end else if (rd_left != 4'h0) begin
        rd_left <= rd_left - 4'h1;
        rd_col <= rd_col + COL_BITS'(2);
        dq_p <= mem[rd_idx];
      end
    end
  end

  // Falling-crossing beat; its slot is one column behind the pointer
  always_ff @(negedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      neg_pend <= 1'b0;
      neg_dq <= '0;
      neg_dm <= '0;
      neg_idx <= '0;
      dq_n <= '0;
    end else begin
      neg_pend <= pos_taken && cke_q;
      neg_dq <= dq_in;
      neg_dm <= dm;
      neg_idx <= {wr_bank, wr_col - COL_BITS'(1)};
      if (rd_on) dq_n <= mem[rd_idx_n];
    end
  end

  // Two byte-masked writes per cycle: this rise, last fall
  always_ff @(posedge ck) begin
    for (int b = 0; b < NB; b++) begin
      if (pos_wr && !dm[b]) mem[wr_idx][b*8+:8] <= dq_in[b*8+:8];
      if (neg_pend && !neg_dm[b]) mem[neg_idx][b*8+:8] <= neg_dq[b*8+:8];
    end
  end

  // Strobe follows the clock so read data is edge-aligned
  assign dq_out = ck ? dq_p : dq_n;
  assign dq_oe = {DQ_W{rd_on}};
  assign dqs_out = {NB{rd_on & ck}};
  assign dqs_oe = {NB{rd_on}};

  // ----------------------------------------
  // Command buffer and crossing to core
  // ----------------------------------------
  lpi_cmd_rec_t fifo [0:BUF_DEPTH-1];
  logic [PW-1:0] f_wp;
  logic [PW-1:0] f_rp;
  logic [PW:0] f_cnt;
  logic f_ready;
  logic push;
  logic pop;
  logic overflow;
  lpi_cmd_rec_t x_data;
  logic x_req;
  logic x_busy;
  logic [2:0] ak_s;
  logic [2:0] rq_s;
  logic rq_seen;
  logic ack_new;
  lpi_cmd_rec_t new_rec;

  assign new_rec = '{cmd: dec_cmd, ba: ca_q.ba, a: ca_q.a};
  assign f_ready = (f_cnt != FULL_CNT);
  assign push = cmd_fire && f_ready;
  assign pop = !x_busy && (f_cnt != '0);
  assign ack_new = x_busy && (ak_s[1] == ak_s[2]) && (ak_s[2] == x_req);

  always_ff @(posedge ck) begin
    if (push) fifo[f_wp] <= new_rec;
  end

  // A stalled core fills the buffer; further commands are dropped and set a sticky overflow flag
  always_ff @(posedge ck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      f_wp <= '0;
      f_rp <= '0;
      f_cnt <= '0;
      overflow <= 1'b0;
      x_data <= '{cmd: CMD_NOP, ba: '0, a: '0};
      x_req <= 1'b0;
      x_busy <= 1'b0;
      ak_s <= 3'h0;
    end else begin
      ak_s <= {ak_s[1:0], rq_seen};
      if (push) f_wp <= f_wp + PW'(1);
      if (pop) f_rp <= f_rp + PW'(1);
      f_cnt <= f_cnt + (PW + 1)'(push) - (PW + 1)'(pop);
      if (cmd_fire && !f_ready) overflow <= 1'b1;
      if (pop) begin
        x_data <= fifo[f_rp];
        x_req <= ~x_req;
        x_busy <= 1'b1;
      end else if (ack_new) begin
        x_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Core side
  // ----------------------------------------
  logic req_new;
  logic [2:0] st_s0;
  logic [2:0] st_s1;
  logic [2:0] st_s2;

  assign req_new = (rq_s[1] == rq_s[2]) && (rq_s[2] != rq_seen) && (!cmd_valid || cmd_ready);

  // Record held still by the sender until our acknowledge returns
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rq_s <= 3'h0;
      rq_seen <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_rec <= '{cmd: CMD_NOP, ba: '0, a: '0};
    end else begin
      rq_s <= {rq_s[1:0], x_req};
      if (req_new) begin
        rq_seen <= rq_s[2];
        cmd_rec <= x_data;
        cmd_valid <= 1'b1;
      end else if (cmd_ready) begin
        cmd_valid <= 1'b0;
      end
    end
  end

  // Self refresh entry and exit change two power-state bits, so a value is taken only when two synced copies agree
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      st_s0 <= 3'h0;
      st_s1 <= 3'h0;
      st_s2 <= 3'h0;
      power_state <= PWR_ACTIVE;
      cmd_overflow <= 1'b0;
      over_temp_flag_out <= 1'b0;
    end else begin
      st_s0 <= {overflow, pwr};
      st_s1 <= st_s0;
      st_s2 <= st_s1;
      if (st_s1 == st_s2) begin
        power_state <= lpi_pwr_t'(st_s2[1:0]);
        cmd_overflow <= st_s2[2];
      end
      over_temp_flag_out <= (temp_c > `LPI_TEMP_W'(`LPI_TEMP_LIMIT_C));
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [IW-1:0] chk_idx;
  logic [7:0] chk_old;
  always_ff @(posedge ck) begin
    chk_idx <= wr_idx;
    chk_old <= mem[wr_idx][7:0];
  end

  sequence s_wr_cmd;
    cmd_fire && (dec_cmd == CMD_WR);
  endsequence
  sequence s_rd_cmd;
    cmd_fire && (dec_cmd == CMD_RD);
  endsequence

  property p_cs_mask;
    @(posedge ck) disable iff (!link_rst_n) (cke_q && ca.cs_n) |=> !cmd_fire;
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command taken with select high");

  property p_act_code;
    @(posedge ck) disable iff (!link_rst_n)
      (cke_q && (pwr == PWR_ACTIVE) && !ca.cs_n && {ca.ras_n, ca.cas_n, ca.we_n} == 3'h3)
      |=> (cmd_fire && dec_cmd == CMD_ACT) ##1 open_bank[$past(ca_q.ba)];
  endproperty
  a_act_code: assert property (p_act_code) else $error("activate not decoded");

  property p_pre_all;
    @(posedge ck) disable iff (!link_rst_n) (cmd_fire && dec_cmd == CMD_PRE && ap)
      |=> (open_bank == '0);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_pd_act;
    @(posedge ck) disable iff (!link_rst_n) (pd_enter && |open_bank) |=> (pwr == PWR_PD_ACT);
  endproperty
  a_pd_act: assert property (p_pd_act) else $error("active power-down not entered");

  property p_sr_exit;
    @(posedge ck) disable iff (!link_rst_n) (pwr == PWR_SELF_REF && cke) |=> (pwr == PWR_ACTIVE);
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self refresh exit missed");

  property p_inputs_off;
    @(posedge ck) disable iff (!link_rst_n) !cke_q |=> (ca_q.cs_n && !pos_wr);
  endproperty
  a_inputs_off: assert property (p_inputs_off) else $error("input taken while disabled");

  property p_drv_off;
    @(posedge ck) disable iff (!link_rst_n) !cke_q |=> (dq_oe == '0 && dqs_oe == '0);
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver on with enable low");

  property p_wr_beats;
    @(posedge ck) disable iff (!link_rst_n) (s_wr_cmd ##1 cke_q) |=> pos_taken;
  endproperty
  a_wr_beats: assert property (p_wr_beats) else $error("write beat not captured");

  property p_rd_strobe;
    @(posedge ck) disable iff (!link_rst_n) (s_rd_cmd ##1 cke_q) |=> (dqs_oe != '0);
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe not driven");

  property p_mask;
    @(posedge ck) disable iff (!link_rst_n)
      (pos_wr && dm[0] && !(neg_pend && neg_idx == wr_idx)) |=> (mem[chk_idx][7:0] == chk_old);
  endproperty
  a_mask: assert property (p_mask) else $error("masked byte was written");

  property p_temp;
    @(posedge clk) disable iff (!core_rst_n)
      (temp_c > `LPI_TEMP_W'(`LPI_TEMP_LIMIT_C)) |=> over_temp_flag_out;
  endproperty
  a_temp: assert property (p_temp) else $error("temperature flag not raised");
endmodule

// File: core/lpi_params.svh
// Constants for the low-power DDR pin interface
`ifndef LPI_PARAMS_SVH
`define LPI_PARAMS_SVH
`define LPI_DQ_W 32
`define LPI_ADDR_W 14
`define LPI_BA_W 2
`define LPI_NBANK 4
`define LPI_AP_BIT 10
`define LPI_COL_BITS 4
`define LPI_BURST_LEN 4
`define LPI_BUF_DEPTH 2
`define LPI_TEMP_W 8
`define LPI_TEMP_LIMIT_C 85
`endif

// File: core/lpi_pkg.sv
// Types shared by the low-power DDR pin interface
`include "lpi_params.svh"
package lpi_pkg;
  // Codes are {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_LMR = 4'h0,
    CMD_REF = 4'h1,
    CMD_PRE = 4'h2,
    CMD_ACT = 4'h3,
    CMD_WR = 4'h4,
    CMD_RD = 4'h5,
    CMD_BST = 4'h6,
    CMD_NOP = 4'h7,
    CMD_DESEL = 4'h8
  } lpi_cmd_t;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_PD_PRE = 2'h1,
    PWR_SELF_REF = 2'h3,
    PWR_PD_ACT = 2'h2
  } lpi_pwr_t;
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [`LPI_BA_W-1:0] ba;
    logic [`LPI_ADDR_W-1:0] a;
  } lpi_ca_t;
  typedef struct packed {
    lpi_cmd_t cmd;
    logic [`LPI_BA_W-1:0] ba;
    logic [`LPI_ADDR_W-1:0] a;
  } lpi_cmd_rec_t;
  localparam lpi_ca_t LPI_CA_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                      ba: '0, a: '0};
  function automatic lpi_cmd_t lpi_decode(input lpi_ca_t c);
    if (c.cs_n) begin
      return CMD_DESEL;
    end
    return lpi_cmd_t'({1'b0, c.ras_n, c.cas_n, c.we_n});
  endfunction
endpackage

// File: bench/lpi_ctl_model.sv
// Memory controller model that drives the LPDDR pins
`timescale 1ns/1ns
module lpi_ctl_model
  import lpi_pkg::*;
(
  // Pins toward the device
  output logic ck,
  output logic cke,
  output lpi_ca_t ca,
  output logic [31:0] dq_in,
  output logic [3:0] dm,
  output logic [3:0] dqs_in,
  // Pins from the device
  input wire logic [31:0] dq_out,
  input wire logic [31:0] dq_oe,
  input wire logic [3:0] dqs_out,
  input wire logic [3:0] dqs_oe
);
  // ----------------------------------------
  // Link clock
  // ----------------------------------------
  initial begin
    ck = 1'b0;
    cke = 1'b0;
    ca = LPI_CA_IDLE;
    dq_in = '0;
    dm = '0;
    #3;
    forever #6 ck = ~ck;
  end
  // Data moves 3 ns after each crossing, so strobe edges sit mid-eye
  assign dqs_in = {4{ck}};

  // ----------------------------------------
  // Pin cycles
  // ----------------------------------------
  task automatic send(input lpi_cmd_rec_t r, input logic k);
    @(posedge ck);
    #1;
    cke = k;
    ca = '{cs_n: r.cmd[3], ras_n: r.cmd[2], cas_n: r.cmd[1], we_n: r.cmd[0],
           ba: r.ba, a: r.a};
    @(posedge ck);
    #1;
    ca = LPI_CA_IDLE;
  endtask

  task automatic burst(input lpi_cmd_rec_t r, input logic [3:0][31:0] w,
      input logic [3:0][3:0] m, output logic [3:0][31:0] q, output logic [7:0] st);
    bit wr;
    wr = (r.cmd == CMD_WR);
    q = '0;
    st = '0;
    send(r, 1'b1);
    @(posedge ck);
    for (int i = 0; i < 4; i++) begin
      if ((i % 2 == 0) == wr) @(negedge ck);
      else @(posedge ck);
      #3;
      if (wr) begin
        dq_in = w[i];
        dm = m[i];
      end else begin
        q[i] = dq_out;
        if (i == 0) st = {dqs_oe, dqs_out};
      end
    end
    @(negedge ck);
    #3;
    // Released lines show the inverse, never a stale copy
    dq_in = ~dq_in;
    dm = ~dm;
  endtask
endmodule

// File: bench/lpddr_pin_interface_bench.sv
// Self-checking bench for the LPDDR pin interface
`timescale 1ns/1ns
module lpddr_pin_interface_bench
  import lpi_pkg::*;
;
  logic clk, rst_n, cmd_ready, over_temp_flag_out, cmd_valid, cmd_overflow;
  logic ck, cke;
  logic [7:0] temp_c;
  lpi_cmd_rec_t cmd_rec;
  lpi_pwr_t power_state;
  lpi_ca_t ca;
  logic [31:0] dq_in, dq_out, dq_oe;
  logic [3:0] dm, dqs_in, dqs_out, dqs_oe;
  logic [3:0][31:0] q, wa, wb;
  logic [7:0] st;
  int failures, checks_done, cycles;
  // Each row is both the pin command and the record it should give
  lpi_cmd_rec_t rows [9] = '{'{CMD_LMR, 2'h2, 14'h0033}, '{CMD_LMR, 2'h0, 14'h0032},
    '{CMD_ACT, 2'h3, 14'h1ABC}, '{CMD_RD, 2'h3, 14'h0005}, '{CMD_WR, 2'h3, 14'h0402},
    '{CMD_BST, 2'h0, 14'h0000}, '{CMD_PRE, 2'h2, 14'h0000}, '{CMD_PRE, 2'h0, 14'h0400},
    '{CMD_REF, 2'h0, 14'h0000}};
  localparam lpi_cmd_rec_t NOP = '{CMD_NOP, 2'h0, 14'h0000};

  lpi_pin_interface DUT (.clk(clk), .rst_n(rst_n), .ck(ck), .cke(cke), .ca(ca),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe), .dm(dm), .temp_c(temp_c), .over_temp_flag_out(over_temp_flag_out),
    .cmd_valid(cmd_valid), .cmd_rec(cmd_rec), .cmd_ready(cmd_ready),
    .power_state(power_state), .cmd_overflow(cmd_overflow));
  lpi_ctl_model ctl (.ck(ck), .cke(cke), .ca(ca), .dq_in(dq_in), .dm(dm), .dqs_in(dqs_in),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe));

  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic expect_rec(input lpi_cmd_rec_t e);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_valid !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check(cmd_valid === 1'b1 && cmd_rec === e, "record mismatch");
    @(posedge clk);
  endtask

  task automatic do_cmd(input lpi_cmd_rec_t r);
    ctl.send(r, 1'b1);
    expect_rec(r);
  endtask

  task automatic xfer(input lpi_cmd_rec_t r, input logic [3:0][31:0] w,
      input logic [3:0][3:0] m);
    ctl.burst(r, w, m, q, st);
    expect_rec(r);
  endtask

  task automatic no_rec(input string msg);
    logic seen;
    seen = 1'b0;
    repeat (30) begin
      @(negedge clk);
      if (cmd_valid === 1'b1) seen = 1'b1;
    end
    check(seen === 1'b0, msg);
  endtask

  task automatic wait_pwr(input lpi_pwr_t e);
    int n;
    n = 0;
    @(negedge clk);
    while (power_state !== e && n < 40) begin
      @(negedge clk);
      n++;
    end
    check(power_state === e, "power state mismatch");
  endtask

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
      input logic [3:0] m);
    logic [31:0] r;
    for (int j = 0; j < 4; j++) r[8*j +: 8] = m[j] ? o[8*j +: 8] : n[8*j +: 8];
    return r;
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    cmd_ready = 1'b1;
    temp_c = 8'h00;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(cmd_valid === 1'b0 && power_state === PWR_ACTIVE, "reset outputs");
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    ctl.send(NOP, 1'b1);
    for (int i = 0; i < 9; i++) do_cmd(rows[i]);
    for (int i = 0; i < 4; i++) begin
      wa[i] = 32'hA0A0A0A0 + 32'(i);
      wb[i] = 32'h5C5C5C5C + 32'(i);
    end
    do_cmd('{CMD_ACT, 2'h1, 14'h0055});
    xfer('{CMD_WR, 2'h1, 14'h000E}, wa, 16'h0000);
    xfer('{CMD_WR, 2'h1, 14'h000E}, wb, 16'hF801);
    // Burst from column 14 wraps to columns 0 and 1
    xfer('{CMD_RD, 2'h1, 14'h0000}, '0, '0);
    check(q[0] === merge(wa[2], wb[2], 4'h8), "wrap beat 0");
    check(q[1] === merge(wa[3], wb[3], 4'hF), "wrap beat 1");
    xfer('{CMD_RD, 2'h1, 14'h040E}, '0, '0);
    check(st === 8'hFF, "read strobe");
    check(dq_oe === 32'h0, "data driver released");
    for (int i = 0; i < 4; i++) check(q[i] === merge(wa[i], wb[i], 4'(16'hF801 >> (4*i))),
      "read data");
    ctl.send(NOP, 1'b0);
    wait_pwr(PWR_PD_PRE);
    ctl.send(NOP, 1'b1);
    wait_pwr(PWR_ACTIVE);
    do_cmd('{CMD_ACT, 2'h2, 14'h0011});
    ctl.send(NOP, 1'b0);
    wait_pwr(PWR_PD_ACT);
    ctl.send('{CMD_ACT, 2'h0, 14'h0022}, 1'b0);
    no_rec("command in power-down");
    ctl.send(NOP, 1'b1);
    wait_pwr(PWR_ACTIVE);
    do_cmd('{CMD_PRE, 2'h0, 14'h0400});
    ctl.send('{CMD_REF, 2'h0, 14'h0000}, 1'b0);
    wait_pwr(PWR_SELF_REF);
    repeat (40) @(posedge clk);
    ctl.send(NOP, 1'b1);
    wait_pwr(PWR_ACTIVE);
    ctl.send('{CMD_DESEL, 2'h0, 14'h0000}, 1'b1);
    ctl.send(NOP, 1'b1);
    no_rec("deselected command");
    // Core stalls while four commands arrive
    check(cmd_overflow === 1'b0, "overflow early");
    @(posedge clk);
    cmd_ready <= 1'b0;
    for (int i = 0; i < 4; i++) ctl.send('{CMD_LMR, 2'(i), 14'h0030}, 1'b1);
    repeat (20) @(posedge clk);
    check(cmd_overflow === 1'b1, "overflow flag");
    cmd_ready <= 1'b1;
    expect_rec('{CMD_LMR, 2'h0, 14'h0030});
    expect_rec('{CMD_LMR, 2'h1, 14'h0030});
    repeat (40) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      temp_c <= (i == 0) ? 8'd85 : (i == 1) ? 8'd86 : (i == 2) ? 8'd84 : 8'd200;
      repeat (3) @(negedge clk);
      check(over_temp_flag_out === 1'(i % 2), "temperature flag");
    end
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    check(cmd_overflow === 1'b0 && power_state === PWR_ACTIVE, "second reset");
    report_and_stop();
  end
endmodule
